/* File: rtl/phy_link_defines.svh */
`ifndef PHY_LINK_DEFINES_SVH
`define PHY_LINK_DEFINES_SVH

// Core clock
`define CLK_PERIOD_NS 10

// Deassertion detection window, least time, rounded up to whole cycles
`define RESET_DETECT_MIN_NS 2600
`define RESET_DETECT_CYCLES \
  ((`RESET_DETECT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Disable detection, no printed figure; must exceed the reset window
`define DISABLE_DETECT_NS 10000
`define DISABLE_DETECT_CYCLES \
  ((`DISABLE_DETECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Clock wake from low-power state, least time, rounded up
`define CLOCK_WAKE_MIN_NS 5300000
`define CLOCK_WAKE_CYCLES \
  ((`CLOCK_WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Start-up sequence, counted in completed link_side_clock periods
`define INIT_RX_PERIOD 4'h7
`define INIT_FLOAT_PERIOD 4'h8
`define INIT_IDLE_PERIOD 4'h9
`define INIT_PERIOD_MAX 4'hF

// Handshake codes
`define CODE_IDLE 2'h0
`define CODE_RECEIVE 2'h2

// Data line patterns
`define DATA_ZERO 8'h00
`define DATA_ONES 8'hFF

// Output enables, active low
`define OE_ON 1'b0
`define OE_OFF 1'b1

// Counter widths and reset values
`define LOW_CNT_W 24
`define WAKE_CNT_W 20
`define LOW_CNT_RESET 24'h000000
`define WAKE_CNT_RESET 20'h00000

`endif

/* File: rtl/phy_link_pkg.sv */
package phy_link_pkg;

  typedef enum logic [1:0] {
    IF_DISABLED,
    IF_WAKING,
    IF_RESET,
    IF_ACTIVE
  } iface_e;

  typedef struct packed {
    logic [1:0] ctl;
    logic ctl_oe_n;
    logic [7:0] data;
    logic data_oe_n;
  } lines_s;

  typedef struct packed {
    iface_e st;
    logic [23:0] low_cnt;
    logic [19:0] wake_cnt;
    logic clk_run;
    logic iface_up;
    logic low_power;
    logic ready;
    logic cancel;
  } core_s;

  typedef struct packed {
    logic run;
    logic ph;
    logic clk_oe_n;
    logic [3:0] per;
    logic op;
    logic accept;
    lines_s lines;
  } link_s;

endpackage

/* File: rtl/bit_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser; the first stage feeds only the second
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [1:0][W-1:0] stage_ff;
  logic [1:0][W-1:0] nxt_stage;

  always_comb begin
    nxt_stage[0] = d;
    nxt_stage[1] = stage_ff[0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  assign q = stage_ff[1];

endmodule

/* File: rtl/phy_link_ctrl.sv */
`timescale 1ns/100ps
`include "phy_link_defines.svh"
// Behaviour
// - Reset interface after 2.60 us of low
// - In reset bring lines to zero, ignore requests
// - Cancel pending requests while not operational
// - Differentiated: end at zero, then float
// - Nondifferentiated: drive lines low in reset
// - Longer low disables and stops the clock
// - Differentiated disable floats the clock output
// - Nondifferentiated disable drives the clock low
// - Hardware reset leaves interface disabled
// - Disabled with no port active: low power
// - Restart clock promptly, or after wake delay
// - Clock starts low half period, then square
// - First full period drives lines low once
// - Eighth period shows receive code, ones
// - Idle code completes start-up, then accept requests
// - Same start-up after reset without disable
module phy_link_ctrl #(
  parameter int DISABLE_CYCLES = `DISABLE_DETECT_CYCLES,
  parameter int WAKE_CYCLES = `CLOCK_WAKE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_SRC_CLK,
  input wire logic LPS_IN,
  input wire logic LINK_REQUEST_LINE_IN,
  input wire logic BARRIER_SEL,
  input wire logic PORT_ACTIVE,
  output phy_link_pkg::lines_s LINES,
  output logic LINK_SIDE_CLOCK_OUT,
  output logic LINK_SIDE_CLOCK_OE_N,
  output logic LINK_REQUEST_LINE_ACCEPT,
  output logic IFACE_READY,
  output logic CANCEL_PENDING,
  output logic LOW_POWER
);

  // Core clock domain

  phy_link_pkg::core_s core_ff;
  phy_link_pkg::core_s nxt_core;
  logic lps_s;
  logic op_s;
  logic low_hit;
  logic dis_hit;
  // Link state declared here, the core side reads its op bit
  phy_link_pkg::link_s link_ff;
  phy_link_pkg::link_s nxt_link;

  bit_sync #(.W(1)) u_lps_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(LPS_IN),
    .q(lps_s)
  );

  // Start-up completion crosses back as a level
  bit_sync #(.W(1)) u_op_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(link_ff.op),
    .q(op_s)
  );

  // Disable window must stay longer than the reset window
  localparam int DISABLE_EFF = (DISABLE_CYCLES > `RESET_DETECT_CYCLES) ?
    DISABLE_CYCLES : `RESET_DETECT_CYCLES + 1;

  assign low_hit = core_ff.low_cnt >= `LOW_CNT_W'(`RESET_DETECT_CYCLES);
  assign dis_hit = core_ff.low_cnt >= `LOW_CNT_W'(DISABLE_EFF);

  always_comb begin
    nxt_core = core_ff;

    // Counts only consecutive low samples; one high restarts it
    if (lps_s) begin
      nxt_core.low_cnt = `LOW_CNT_RESET;
    end else if (!dis_hit) begin
      nxt_core.low_cnt = core_ff.low_cnt + `LOW_CNT_W'(1);
    end

    unique case (core_ff.st)
      phy_link_pkg::IF_DISABLED: begin
        nxt_core.wake_cnt = `WAKE_CNT_RESET;
        if (lps_s) begin
          if (core_ff.low_power) begin
            nxt_core.st = phy_link_pkg::IF_WAKING;
          end else begin
            nxt_core.st = phy_link_pkg::IF_ACTIVE;
          end
        end
      end
      phy_link_pkg::IF_WAKING: begin
        // Oscillator restart time in low power
        nxt_core.wake_cnt = core_ff.wake_cnt + `WAKE_CNT_W'(1);
        if (core_ff.wake_cnt >= `WAKE_CNT_W'(WAKE_CYCLES - 1)) begin
          nxt_core.st = phy_link_pkg::IF_ACTIVE;
        end
      end
      phy_link_pkg::IF_ACTIVE: begin
        if (low_hit) begin
          nxt_core.st = phy_link_pkg::IF_RESET;
        end
      end
      phy_link_pkg::IF_RESET: begin
        if (lps_s) begin
          nxt_core.st = phy_link_pkg::IF_ACTIVE;
        end else if (dis_hit) begin
          nxt_core.st = phy_link_pkg::IF_DISABLED;
        end
      end
    endcase

    // Clock keeps running in reset, stops when disabled and stays stopped while waking
    nxt_core.clk_run = (nxt_core.st == phy_link_pkg::IF_ACTIVE) ||
                       (nxt_core.st == phy_link_pkg::IF_RESET);
    nxt_core.iface_up = (nxt_core.st == phy_link_pkg::IF_ACTIVE);
    nxt_core.low_power = 1'b0;
    if (nxt_core.st == phy_link_pkg::IF_DISABLED && !PORT_ACTIVE) begin
      nxt_core.low_power = 1'b1;
    end
    // Cancel has its own flop so the pin comes straight from a register
    nxt_core.ready = 1'b0;
    nxt_core.cancel = 1'b1;
    if (core_ff.iface_up && op_s) begin
      nxt_core.ready = 1'b1;
      nxt_core.cancel = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      core_ff.st <= phy_link_pkg::IF_DISABLED;
      core_ff.low_cnt <= `LOW_CNT_RESET;
      core_ff.wake_cnt <= `WAKE_CNT_RESET;
      core_ff.clk_run <= 1'b0;
      core_ff.iface_up <= 1'b0;
      core_ff.low_power <= 1'b0;
      core_ff.ready <= 1'b0;
      core_ff.cancel <= 1'b1;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign LOW_POWER = core_ff.low_power;
  assign IFACE_READY = core_ff.ready;
  // Queued requests and status are dropped, not held for later
  assign CANCEL_PENDING = core_ff.cancel;

  // Link clock domain

  logic lrst_n;
  logic run_s;
  logic up_s;
  logic link_request_line_s;
  logic barrier_s;
  logic wrap;

  // Reset reaches the link side through its own synchroniser
  bit_sync #(.W(1)) u_rst_sync (
    .clk(LINK_SRC_CLK),
    .rst_n(1'b1),
    .d(RST_N),
    .q(lrst_n)
  );

  bit_sync #(.W(2)) u_ctl_sync (
    .clk(LINK_SRC_CLK),
    .rst_n(lrst_n),
    .d({core_ff.clk_run, core_ff.iface_up}),
    .q({run_s, up_s})
  );

  bit_sync #(.W(2)) u_pin_sync (
    .clk(LINK_SRC_CLK),
    .rst_n(lrst_n),
    .d({LINK_REQUEST_LINE_IN, BARRIER_SEL}),
    .q({link_request_line_s, barrier_s})
  );

  // A period ends on the high-to-low step of the output clock
  assign wrap = run_s && link_ff.run && link_ff.ph;

  always_comb begin
    nxt_link = link_ff;
    nxt_link.run = run_s;

    if (!run_s) begin
      nxt_link.ph = 1'b0;
      // Float when differentiated, else hold it low
      if (barrier_s) begin
        nxt_link.clk_oe_n = `OE_ON;
      end else begin
        nxt_link.clk_oe_n = `OE_OFF;
      end
    end else begin
      nxt_link.clk_oe_n = `OE_ON;
      // First edge after start holds the clock low
      if (link_ff.run) begin
        nxt_link.ph = !link_ff.ph;
      end else begin
        nxt_link.ph = 1'b0;
      end
    end

    nxt_link.lines.ctl = `CODE_IDLE;
    nxt_link.lines.data = `DATA_ZERO;

    if (!up_s) begin
      nxt_link.per = 4'h0;
      nxt_link.op = 1'b0;
      if (barrier_s) begin
        nxt_link.lines.ctl_oe_n = `OE_ON;
      end else if (link_ff.lines.ctl == `CODE_IDLE &&
                   link_ff.lines.data == `DATA_ZERO) begin
        // Lines already at zero, safe to release
        nxt_link.lines.ctl_oe_n = `OE_OFF;
      end else begin
        nxt_link.lines.ctl_oe_n = `OE_ON;
      end
    end else begin
      if (wrap && link_ff.per != `INIT_PERIOD_MAX) begin
        nxt_link.per = link_ff.per + 4'h1;
      end
      if (!link_ff.run) begin
        // Clock not yet started: keep reset line states
        if (barrier_s) begin
          nxt_link.lines.ctl_oe_n = `OE_ON;
        end else begin
          nxt_link.lines.ctl_oe_n = `OE_OFF;
        end
      end else if (nxt_link.per == 4'h0) begin
        nxt_link.lines.ctl_oe_n = `OE_ON;
      end else if (nxt_link.per < `INIT_RX_PERIOD) begin
        // Far end may drive low here, so differentiated lines let go
        if (barrier_s) begin
          nxt_link.lines.ctl_oe_n = `OE_ON;
        end else begin
          nxt_link.lines.ctl_oe_n = `OE_OFF;
        end
      end else if (nxt_link.per == `INIT_RX_PERIOD) begin
        nxt_link.lines.ctl = `CODE_RECEIVE;
        nxt_link.lines.data = `DATA_ONES;
        nxt_link.lines.ctl_oe_n = `OE_ON;
      end else if (nxt_link.per == `INIT_FLOAT_PERIOD) begin
        // Differentiated lines float after one receive cycle
        nxt_link.lines.ctl = `CODE_RECEIVE;
        nxt_link.lines.data = `DATA_ONES;
        // Values kept so a late float still leaves them defined
        if (barrier_s) begin
          nxt_link.lines.ctl_oe_n = `OE_ON;
        end else begin
          nxt_link.lines.ctl_oe_n = `OE_OFF;
        end
      end else begin
        nxt_link.lines.ctl = `CODE_IDLE;
        nxt_link.lines.ctl_oe_n = `OE_ON;
        nxt_link.op = (nxt_link.per >= `INIT_IDLE_PERIOD);
      end
    end
    nxt_link.lines.data_oe_n = nxt_link.lines.ctl_oe_n;

    // Requests only count once start-up has finished
    nxt_link.accept = link_request_line_s && link_ff.op && up_s;
  end

  always_ff @(posedge LINK_SRC_CLK) begin
    if (!lrst_n) begin
      link_ff.run <= 1'b0;
      link_ff.ph <= 1'b0;
      link_ff.clk_oe_n <= `OE_OFF;
      link_ff.per <= 4'h0;
      link_ff.op <= 1'b0;
      link_ff.accept <= 1'b0;
      link_ff.lines.ctl <= `CODE_IDLE;
      link_ff.lines.ctl_oe_n <= `OE_OFF;
      link_ff.lines.data <= `DATA_ZERO;
      link_ff.lines.data_oe_n <= `OE_OFF;
    end else begin
      link_ff <= nxt_link;
    end
  end

  assign LINES = link_ff.lines;
  assign LINK_SIDE_CLOCK_OUT = link_ff.ph;
  assign LINK_SIDE_CLOCK_OE_N = link_ff.clk_oe_n;
  assign LINK_REQUEST_LINE_ACCEPT = link_ff.accept;

endmodule

/* File: tb/phy_link_ctrl_props.sv */
`timescale 1ns/100ps
module phy_link_ctrl_props #(
  parameter int DISABLE_CYCLES = 600,
  parameter int WAKE_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_SRC_CLK,
  input wire logic LPS_IN,
  input wire logic BARRIER_SEL,
  input wire logic PORT_ACTIVE,
  input wire phy_link_pkg::lines_s LINES,
  input wire logic LINK_SIDE_CLOCK_OUT,
  input wire logic LINK_REQUEST_LINE_ACCEPT,
  input wire logic IFACE_READY,
  input wire logic CANCEL_PENDING,
  input wire logic LOW_POWER
);
  // Raw pin count; the design sees the pin two flops late
  logic [15:0] low_ff;
  always_ff @(posedge CLK) begin
    if (!RST_N || LPS_IN) begin
      low_ff <= 16'h0000;
    end else if (low_ff != 16'hFFFF) begin
      low_ff <= low_ff + 16'h0001;
    end
  end
  property p_early;
    @(posedge CLK) disable iff (!RST_N)
      IFACE_READY && low_ff != 16'h0000 && low_ff < 16'h00FA |=> IFACE_READY;
  endproperty
  a_early: assert property (p_early) else $error("early reset");
  property p_late;
    @(posedge CLK) disable iff (!RST_N) low_ff == 16'h0113 |-> !IFACE_READY;
  endproperty
  a_late: assert property (p_late) else $error("no reset");
  property p_disable;
    @(posedge CLK) disable iff (!RST_N)
      low_ff == 16'(DISABLE_CYCLES + 8) && !PORT_ACTIVE |-> LOW_POWER;
  endproperty
  a_disable: assert property (p_disable) else $error("no low power");
  property p_cancel;
    @(posedge CLK) disable iff (!RST_N)
      CANCEL_PENDING == !IFACE_READY && (low_ff < 16'h0113 || CANCEL_PENDING);
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel wrong");
  property p_accept;
    @(posedge LINK_SRC_CLK) disable iff (!RST_N)
      LINK_REQUEST_LINE_ACCEPT |-> LINES.ctl == 2'h0 && LINES.data == 8'h00;
  endproperty
  a_accept: assert property (p_accept) else $error("accept early");
  property p_clk_sq;
    @(posedge LINK_SRC_CLK) disable iff (!RST_N) $rose(LINK_SIDE_CLOCK_OUT) |=> $fell(LINK_SIDE_CLOCK_OUT);
  endproperty
  a_clk_sq: assert property (p_clk_sq) else $error("clock shape");
  property p_rx_len;
    @(posedge LINK_SRC_CLK) disable iff (!RST_N) $rose(LINES.ctl[1]) |->
      (LINES.ctl == 2'h2 && LINES.data == 8'hFF) [*4] ##1
      (LINES.ctl == 2'h0 && LINES.data == 8'h00);
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("receive phase");
  property p_nondiff;
    @(posedge LINK_SRC_CLK) disable iff (!RST_N)
      BARRIER_SEL && $past(BARRIER_SEL, 8) && $past(RST_N, 8) |-> !LINES.ctl_oe_n;
  endproperty
  a_nondiff: assert property (p_nondiff) else $error("lines floated");
  c_ready: cover property (@(posedge CLK) $rose(IFACE_READY));
  c_lp: cover property (@(posedge CLK) $rose(LOW_POWER));
  c_rx: cover property (@(posedge LINK_SRC_CLK) $rose(LINES.ctl[1]));
endmodule

bind phy_link_ctrl phy_link_ctrl_props #(
  .DISABLE_CYCLES(DISABLE_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)
) phy_link_ctrl_props_inst (.CLK, .RST_N, .LINK_SRC_CLK, .LPS_IN, .BARRIER_SEL,
  .PORT_ACTIVE, .LINES, .LINK_SIDE_CLOCK_OUT, .LINK_REQUEST_LINE_ACCEPT, .IFACE_READY, .CANCEL_PENDING,
  .LOW_POWER);

/* File: tb/llc_model.sv */
`timescale 1ns/100ps
module llc_model #(
  parameter logic [9:0] RESTORE = 10'h020
) (
  input wire logic clk,
  input wire logic want_up,
  input wire logic pulsed,
  input wire logic req,
  output logic link_power_status,
  output logic link_request_line
);
  logic up = 1'b0;
  logic [6:0] ph = 7'h00;
  logic [9:0] low_run = 10'h000;
  logic [7:0] on_run = 8'h00;
  always @(negedge clk) begin
    ph <= (ph == 7'h63) ? 7'h00 : ph + 7'h01;
    low_run <= up ? 10'h000 : low_run + {9'h000, low_run != 10'h3FF};
    on_run <= up ? on_run + {7'h00, on_run != 8'hFF} : 8'h00;
    up <= want_up && (up || low_run >= RESTORE);
  end
  // Pulse 30 of 100 cycles keeps both halves short
  assign link_power_status = up && (!pulsed || ph < 7'h1E);
  // Quiet while down and through early start-up
  assign link_request_line = up && req && on_run > 8'h60;
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic want_up = 1'b0;
  logic pulsed = 1'b0;
  logic req = 1'b1;
  logic barrier = 1'b0;
  logic port = 1'b0;
  logic link_power_status, link_request_line, sclk, sclk_oe_n, acc, rdy, cancel, lp;
  phy_link_pkg::lines_s lines;
  int err_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #40 lclk = ~lclk;
  end
  llc_model llc_model_inst (.clk, .want_up, .pulsed, .req, .link_power_status, .link_request_line);
  phy_link_ctrl #(.DISABLE_CYCLES(600), .WAKE_CYCLES(20)) phy_link_ctrl_inst (.CLK(clk),
    .RST_N(rst_n), .LINK_SRC_CLK(lclk), .LPS_IN(link_power_status), .LINK_REQUEST_LINE_IN(link_request_line), .BARRIER_SEL(barrier),
    .PORT_ACTIVE(port), .LINES(lines), .LINK_SIDE_CLOCK_OUT(sclk), .LINK_SIDE_CLOCK_OE_N(sclk_oe_n),
    .LINK_REQUEST_LINE_ACCEPT(acc), .IFACE_READY(rdy), .CANCEL_PENDING(cancel), .LOW_POWER(lp));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t saw %h not %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic go_up;
    int n;
    n = 0;
    wait_clk(1);
    want_up = 1'b1;
    wait_clk(130);
    check(12'(acc), 12'h000);
    while (rdy !== 1'b1 && n < 2000) begin
      wait_clk(1);
      n++;
    end
    check(12'(rdy), 12'h001);
    wait_clk(60);
    check(12'(acc), 12'h001);
  endtask
  task automatic t_reset_only;
    want_up = 1'b0;
    wait_clk(240);
    check(12'(rdy), 12'h001);
    wait_clk(80);
    check(12'({rdy, cancel, acc}), 12'h002);
    check(lines, {2'h0, ~barrier, 8'h00, ~barrier});
    check(12'(sclk_oe_n), 12'h000);
    go_up();
  endtask
  task automatic t_disable;
    want_up = 1'b0;
    wait_clk(700);
    check(lines, {2'h0, ~barrier, 8'h00, ~barrier});
    check(12'({lp, cancel}), 12'({~port, 1'b1}));
    repeat (3) begin
      @(negedge lclk);
      check(12'({sclk, sclk_oe_n}), 12'({1'b0, ~barrier}));
    end
    go_up();
  endtask
  task automatic t_pulsed;
    pulsed = 1'b1;
    repeat (20) begin
      wait_clk(100);
      check(12'(rdy), 12'h001);
    end
    pulsed = 1'b0;
  endtask
  initial begin
    wait_clk(40);
    rst_n = 1'b1;
    wait_clk(40);
    check(12'({rdy, cancel, sclk_oe_n, lp}), 12'h007);
    for (int i = 0; i < 4; i++) begin
      barrier = i[1];
      port = i[0];
      t_disable();
      t_reset_only();
    end
    t_pulsed();
    final_report();
  end
  initial begin
    #300000;
    err_count++;
    final_report();
  end
endmodule
